// ===== core/lrb_defs.svh
// Offsets, field positions and reset values of the LIN register front end
`ifndef LRB_DEFS_SVH
`define LRB_DEFS_SVH
// Direct register addresses
`define LRB_SFR_CONFIG 8'h95
`define LRB_SFR_INDADDR 8'h92
`define LRB_SFR_INDDATA 8'h93
// Indirect addresses
`define LRB_IND_DATA_LAST 4'h7
`define LRB_IND_CONTROL 4'h8
`define LRB_IND_STATUS 4'h9
`define LRB_IND_ERROR 4'ha
`define LRB_IND_SIZE 4'hb
`define LRB_IND_DIVIDER 4'hc
`define LRB_IND_MULT 4'hd
`define LRB_IND_IDENT 4'he
// Configuration bits
`define LRB_CF_ENABLE 7
`define LRB_CF_MASTER 6
`define LRB_CF_AUTO_BAUD_SELECT 5
`define LRB_CF_MASK 8'he0
// Control bits
`define LRB_CT_STOP 7
`define LRB_CT_SLEEP 6
`define LRB_CT_DIR 5
`define LRB_CT_DATA_ACKNOWLEDGE 4
`define LRB_CT_INTERRUPT_RESET 3
`define LRB_CT_ERROR_RESET 2
`define LRB_CT_WAKEUP_REQUEST 1
`define LRB_CT_START 0
// Status bits
`define LRB_ST_ACTIVE 7
`define LRB_ST_IDLE 6
`define LRB_ST_ABORT 5
`define LRB_ST_DATA_REQUEST_FLAG 4
`define LRB_ST_INT 3
`define LRB_ST_ERROR 2
`define LRB_ST_WAKEUP 1
`define LRB_ST_DONE 0
// Error bits kept only in slave role
`define LRB_ERR_SLAVE_MASK 5'h18
// Implemented bits of size and identifier registers
`define LRB_SIZE_MASK 8'h8f
`define LRB_ID_MASK 8'h3f
// Reset value of every register
`define LRB_RESET_BYTE 8'h00
`endif

// ===== core/lrb_pkg.sv
// Types shared by the LIN register front end
package lrb_pkg;
  // Role of the controller on the bus
  typedef enum logic {LRB_SLAVE, LRB_MASTER} lrb_role_t;
endpackage

// ===== core/lrb_bank.sv
// LIN register bank: configuration, indirect access path and protocol registers
//
// How it works
// RQ1: configuration holds enable, role, autobaud bits
// RQ2: protocol registers reached only through indirect addresses
// RQ3: same register set in both roles
// RQ4: master-only bits usable only in master role
// RQ5: slave-only bits usable only in slave role
// RQ6: control register field layout at 0x08
// RQ7: status register field layout at 0x09
// RQ8: eight data bytes, read/write, reset zero
// RQ9: slave software touches data only when requested; not enforced, the data bytes stay open to CPU access in both roles
// RQ10: error reset clears error flags and register
// RQ11: no start or wakeup while error set
// RQ12: indirect access uses last written address
`timescale 1ns/1ps
`default_nettype none
`include "lrb_defs.svh"
module lrb_bank (
  input wire logic i_mclk,
  input wire logic i_rst,
  // CPU special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Events from the frame engine, one-cycle pulses on this clock, except i_bus_active, which is a level
  input wire logic i_bus_active,
  input wire logic i_evt_done,
  input wire logic i_evt_wakeup,
  input wire logic i_evt_idle,
  input wire logic i_evt_abort,
  input wire logic i_evt_data_request_flag,
  input wire logic [4:0] i_evt_err,
  input wire logic i_rx_we,
  input wire logic [2:0] i_rx_idx,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_id_we,
  input wire logic [5:0] i_id,
  input wire logic [2:0] i_tx_idx,
  // Settings and requests toward the frame engine
  output logic [7:0] o_tx_byte,
  output logic o_enable,
  output logic o_master,
  output logic o_auto_baud,
  output logic o_start_req,
  output logic o_wakeup_req,
  output logic o_data_acknowledge_req,
  output logic o_stop,
  output logic o_sleep,
  output logic o_direction,
  output logic [7:0] o_size,
  output logic [7:0] o_divider,
  output logic [7:0] o_multiplier,
  output logic [5:0] o_identifier
);

  // Direct registers
  logic [7:0] cfg_q; // Configuration
  logic [3:0] iaddr_q; // Indirect address select
  logic [7:0] rdata_q; // Registered read data
  // Indirect registers
  logic [7:0] data_q [0:7]; // Frame data bytes
  logic sleep_q, dir_q, data_acknowledge_q, wup_q, start_q, stop_q;
  logic idle_q, abort_q, data_request_flag_q, int_q, err_q, wake_q, done_q;
  logic [4:0] errf_q; // Error flags
  logic [7:0] size_q, div_q, mul_q;
  logic [5:0] id_q;

  // Role and enable decode
  lrb_pkg::lrb_role_t role;
  wire en = cfg_q[`LRB_CF_ENABLE]; // RQ1
  assign role = cfg_q[`LRB_CF_MASTER] ? lrb_pkg::LRB_MASTER : lrb_pkg::LRB_SLAVE; // RQ1
  wire is_m = (role == lrb_pkg::LRB_MASTER);
  wire is_s = !is_m;

  // Direct address decode
  wire wr_cfg = i_sfr_wr && (i_sfr_addr == `LRB_SFR_CONFIG);
  wire wr_ia = i_sfr_wr && (i_sfr_addr == `LRB_SFR_INDADDR);
  wire wr_id = i_sfr_wr && (i_sfr_addr == `LRB_SFR_INDDATA);
  wire rd_id = i_sfr_rd && (i_sfr_addr == `LRB_SFR_INDDATA);
  wire [7:0] wd = i_sfr_wdata;

  // Indirect write strobes, selected by the held address
  wire w_data = wr_id && (iaddr_q <= `LRB_IND_DATA_LAST); // RQ12
  wire w_ctl = wr_id && (iaddr_q == `LRB_IND_CONTROL); // RQ6
  wire w_size = wr_id && (iaddr_q == `LRB_IND_SIZE);
  wire w_div = wr_id && (iaddr_q == `LRB_IND_DIVIDER);
  wire w_mul = wr_id && (iaddr_q == `LRB_IND_MULT);
  wire w_ident = wr_id && (iaddr_q == `LRB_IND_IDENT);

  // Control write effects; role gating drops the other role's bits
  wire c_interrupt_reset = w_ctl && wd[`LRB_CT_INTERRUPT_RESET];
  wire c_error_reset = w_ctl && wd[`LRB_CT_ERROR_RESET]; // RQ10
  wire c_stop = w_ctl && wd[`LRB_CT_STOP] && is_s; // RQ5
  wire c_data_acknowledge = w_ctl && wd[`LRB_CT_DATA_ACKNOWLEDGE] && is_s; // RQ5
  // Requests refused while the error flag stands, cleared or not this cycle
  wire c_start = w_ctl && wd[`LRB_CT_START] && is_m && !err_q; // RQ4 RQ11
  wire c_wup = w_ctl && wd[`LRB_CT_WAKEUP_REQUEST] && !err_q; // RQ11

  // Events only count while the controller is enabled
  wire e_err = en && (i_evt_err != 5'h00);
  wire e_done = en && i_evt_done;
  wire e_wake = en && i_evt_wakeup;
  wire e_idle = en && i_evt_idle;
  wire e_abort = en && i_evt_abort && is_s; // RQ5
  wire e_data_request_flag = en && i_evt_data_request_flag && is_s; // RQ5
  wire e_any = e_err || e_done || e_wake || e_idle || e_abort || e_data_request_flag;
  wire frame_end = e_done || e_err;
  // Slave-only error causes are not recorded in master role
  wire [4:0] err_in = is_m ? (i_evt_err & ~`LRB_ERR_SLAVE_MASK) : i_evt_err; // RQ5

  // Read views with role masks applied
  wire [7:0] ctl_rd = {1'b0, sleep_q & is_s, dir_q, data_acknowledge_q & is_s, 2'b00, wup_q,
    start_q & is_m}; // RQ6 RQ4 RQ5
  wire [7:0] st_rd = {i_bus_active, idle_q, abort_q & is_s, data_request_flag_q & is_s, int_q,
    err_q, wake_q, done_q}; // RQ7
  wire [7:0] err_rd = {3'b000, errf_q & (is_s ? 5'h1f : ~`LRB_ERR_SLAVE_MASK)};

  // Indirect read multiplexer; holes read zero
  logic [7:0] ind_rd;
  always_comb
  begin
    ind_rd = `LRB_RESET_BYTE;
    if (iaddr_q <= `LRB_IND_DATA_LAST)
      ind_rd = data_q[iaddr_q[2:0]]; // RQ2 RQ8
    else
      case (iaddr_q)
        `LRB_IND_CONTROL: ind_rd = ctl_rd;
        `LRB_IND_STATUS: ind_rd = st_rd;
        `LRB_IND_ERROR: ind_rd = err_rd;
        `LRB_IND_SIZE: ind_rd = size_q;
        `LRB_IND_DIVIDER: ind_rd = div_q;
        `LRB_IND_MULT: ind_rd = mul_q;
        `LRB_IND_IDENT: ind_rd = {2'b00, id_q};
        default: ind_rd = `LRB_RESET_BYTE; // RQ12
      endcase
  end

  // Direct read multiplexer; unmapped addresses read zero
  wire [7:0] sfr_rd = (i_sfr_addr == `LRB_SFR_CONFIG) ? cfg_q :
    (i_sfr_addr == `LRB_SFR_INDADDR) ? {4'h0, iaddr_q} :
    (i_sfr_addr == `LRB_SFR_INDDATA) ? ind_rd : `LRB_RESET_BYTE;

  // Direct registers and read data
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_q <= `LRB_RESET_BYTE;
      iaddr_q <= 4'h0;
      rdata_q <= `LRB_RESET_BYTE;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= wd & `LRB_CF_MASK; // RQ1
      if (wr_ia)
        iaddr_q <= wd[3:0]; // RQ12
      if (i_sfr_rd)
        rdata_q <= sfr_rd;
    end
  end

  // Data bytes: engine receive writes win over CPU writes to the same byte
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 8; k++)
        data_q[k] <= `LRB_RESET_BYTE; // RQ8
    end
    else
    begin
      if (w_data)
        data_q[iaddr_q[2:0]] <= wd; // RQ8
      if (i_rx_we)
        data_q[i_rx_idx] <= i_rx_byte;
    end
  end

  // Plain settings registers, same in both roles except sleep, which is written only in slave role
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      size_q <= `LRB_RESET_BYTE;
      div_q <= `LRB_RESET_BYTE;
      mul_q <= `LRB_RESET_BYTE;
      id_q <= 6'h00;
      dir_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      if (w_size)
        size_q <= wd & `LRB_SIZE_MASK; // RQ3
      if (w_div)
        div_q <= wd;
      if (w_mul)
        mul_q <= wd;
      // Slave engine captures the header identifier
      if (i_id_we)
        id_q <= i_id;
      else if (w_ident)
        id_q <= wd[5:0];
      if (w_ctl)
        dir_q <= wd[`LRB_CT_DIR]; // RQ6
      if (w_ctl && is_s)
        sleep_q <= wd[`LRB_CT_SLEEP]; // RQ5
    end
  end

  // Requests: start and acknowledge held until the frame ends, wakeup until frame end or wakeup event, so the engine sees a level; stop is a one-cycle pulse
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      start_q <= 1'b0;
      wup_q <= 1'b0;
      data_acknowledge_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else
    begin
      // Set wins over the end of the previous frame
      start_q <= c_start || (start_q && !frame_end && is_m); // RQ4 RQ11
      wup_q <= c_wup || (wup_q && !frame_end && !e_wake); // RQ11
      data_acknowledge_q <= c_data_acknowledge || (data_acknowledge_q && !frame_end && is_s); // RQ5
      stop_q <= c_stop; // RQ5
    end
  end

  // Status flags: hardware set wins over software clear in the same cycle
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      idle_q <= 1'b0;
      abort_q <= 1'b0;
      data_request_flag_q <= 1'b0;
      int_q <= 1'b0;
      err_q <= 1'b0;
      wake_q <= 1'b0;
      done_q <= 1'b0;
      errf_q <= 5'h00;
    end
    else
    begin
      idle_q <= e_idle || (idle_q && !c_interrupt_reset); // RQ7
      abort_q <= e_abort || (abort_q && !c_interrupt_reset);
      // Data request ends when software acknowledges or stops the frame
      data_request_flag_q <= e_data_request_flag || (data_request_flag_q && !c_data_acknowledge && !c_stop && !c_interrupt_reset);
      int_q <= e_any || (int_q && !c_interrupt_reset);
      wake_q <= e_wake || (wake_q && !c_interrupt_reset);
      done_q <= e_done || e_wake || (done_q && !c_interrupt_reset);
      err_q <= e_err || (err_q && !c_error_reset); // RQ10
      errf_q <= (en ? err_in : 5'h00) | (c_error_reset ? 5'h00 : errf_q); // RQ10
    end
  end

  // Output drive
  assign o_sfr_rdata = rdata_q;
  assign o_tx_byte = data_q[i_tx_idx];
  assign o_enable = en;
  assign o_master = is_m;
  assign o_auto_baud = cfg_q[`LRB_CF_AUTO_BAUD_SELECT] && is_s; // RQ1
  assign o_start_req = start_q;
  assign o_wakeup_req = wup_q;
  assign o_data_acknowledge_req = data_acknowledge_q;
  assign o_stop = stop_q;
  assign o_sleep = sleep_q && is_s;
  assign o_direction = dir_q;
  assign o_size = size_q;
  assign o_divider = div_q;
  assign o_multiplier = mul_q;
  assign o_identifier = id_q;

  // Checks
  a_start_err_refused: assert property (@(posedge i_mclk) disable iff (i_rst)
    (err_q && w_ctl && wd[0]) |=> !start_q || $past(start_q)) // RQ11
    else $error("start accepted while error flag set");
  a_start_slave_ignored: assert property (@(posedge i_mclk) disable iff (i_rst)
    (is_s && !$past(start_q)) |-> !start_q) // RQ4
    else $error("start request taken in slave role");
  a_wakeup_err_refused: assert property (@(posedge i_mclk) disable iff (i_rst)
    (err_q && !wup_q) |=> !wup_q) // RQ11
    else $error("wakeup accepted while error flag set");
  a_error_reset_clears_error: assert property (@(posedge i_mclk) disable iff (i_rst)
    (c_error_reset && !e_err) |=> !err_q && errf_q == 5'h00) // RQ10
    else $error("error reset left error state");
  a_error_set_wins: assert property (@(posedge i_mclk) disable iff (i_rst)
    e_err |=> err_q && ((errf_q & $past(err_in)) == $past(err_in))) // RQ10
    else $error("error event lost");
  a_master_slave_err_hidden: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_id && is_m && iaddr_q == `LRB_IND_ERROR) |=> rdata_q[4:3] == 2'b00) // RQ5
    else $error("slave-only error bit visible in master role");
  a_data_byte_write: assert property (@(posedge i_mclk) disable iff (i_rst)
    (w_data && !i_rx_we) |=> data_q[$past(iaddr_q[2:0])] == $past(wd)) // RQ8
    else $error("data byte write not stored");
  a_indirect_read_path: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_id && iaddr_q > `LRB_IND_IDENT) |=> rdata_q == 8'h00) // RQ12
    else $error("unused indirect address read nonzero");
  a_status_readback: assert property (@(posedge i_mclk) disable iff (i_rst)
    (rd_id && iaddr_q == `LRB_IND_STATUS) |=> rdata_q[2] == $past(err_q)
    && rdata_q[7] == $past(i_bus_active)) // RQ7
    else $error("status read does not match flags");
  a_config_fields: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr_cfg |=> o_enable == $past(wd[7]) && o_master == $past(wd[6])) // RQ1
    else $error("configuration write not applied");
  a_sleep_slave_only: assert property (@(posedge i_mclk) disable iff (i_rst)
    is_m |-> !o_sleep && !data_acknowledge_q) // RQ5 RQ3
    else $error("slave-only control active in master role");

endmodule
`default_nettype wire

// ===== test/lrb_engine_model.sv
// Frame engine stand-in that answers start and wakeup requests
`timescale 1ns/1ps
`default_nettype none
module lrb_engine_model #(
  parameter int unsigned DELAY = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start_req,
  input wire logic i_wakeup_req,
  input wire logic i_fault,
  input wire logic i_slow,
  output logic o_bus_active,
  output logic o_evt_done,
  output logic o_evt_wakeup,
  output logic [4:0] o_evt_err
);
  logic [7:0] cnt_q; // Cycles spent on the job
  logic wake_q; // Job is a wakeup, not a frame
  logic [7:0] len; // Job length, long when slow
  logic idle; // No job and no event on show
  assign len = i_slow ? 8'h28 : DELAY[7:0];
  assign idle = !o_bus_active && !o_evt_done && !o_evt_wakeup && (o_evt_err == 5'h00);
  // Rest a cycle after each event so a request still held is not taken twice
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_bus_active <= 1'b0;
      o_evt_done <= 1'b0;
      o_evt_wakeup <= 1'b0;
      o_evt_err <= 5'h00;
      cnt_q <= 8'h00;
      wake_q <= 1'b0;
    end
    else
    begin
      o_evt_done <= 1'b0;
      o_evt_wakeup <= 1'b0;
      o_evt_err <= 5'h00;
      if (idle && (i_start_req || i_wakeup_req))
      begin
        o_bus_active <= 1'b1;
        cnt_q <= 8'h00;
        wake_q <= i_wakeup_req;
      end
      else if (o_bus_active)
      begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == len)
        begin
          o_bus_active <= 1'b0;
          // Commanded fault ends the job with a bit error
          if (i_fault)
            o_evt_err <= 5'h01;
          else if (wake_q)
            o_evt_wakeup <= 1'b1;
          else
            o_evt_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/lin_indirect_register_bank_bench.sv
// Self-checking bench for the LIN register bank
`timescale 1ns/1ps
`default_nettype none
`include "lrb_defs.svh"
module lin_indirect_register_bank_bench;
  typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} lrb_row_t;
  logic mclk, rst, wr_s, rd_s, act, done, wake, rx_we, fault, slow;
  logic [7:0] addr, wdata, rdata, rx_byte, tx_byte, d, size;
  logic [4:0] err;
  logic [2:0] rx_idx, tx_idx;
  logic en, mst, ab, sreq, wreq, sleep;
  int n_errors = 0;
  int tests_run = 0;
  // Plain rows: indirect address, value written, value read back
  lrb_row_t rows [9] = '{'{4'h0, 8'h5a, 8'h5a}, '{4'h7, 8'ha5, 8'ha5},
    '{4'hb, 8'hff, 8'h8f}, '{4'hc, 8'hff, 8'hff}, '{4'hd, 8'h81, 8'h81},
    '{4'he, 8'hff, 8'h3f}, '{4'hf, 8'hff, 8'h00}, '{4'ha, 8'hff, 8'h00},
    '{4'h9, 8'hff, 8'h00}};
  // Engine events come from the model; rarer slave events are tied off
  lrb_bank dut (.i_mclk(mclk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr_s),
    .i_sfr_rd(rd_s), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_bus_active(act),
    .i_evt_done(done), .i_evt_wakeup(wake), .i_evt_idle(1'b0), .i_evt_abort(1'b0),
    .i_evt_data_request_flag(1'b0), .i_evt_err(err), .i_rx_we(rx_we), .i_rx_idx(rx_idx),
    .i_rx_byte(rx_byte), .i_id_we(1'b0), .i_id(6'h00), .i_tx_idx(tx_idx),
    .o_tx_byte(tx_byte), .o_enable(en), .o_master(mst), .o_auto_baud(ab),
    .o_start_req(sreq), .o_wakeup_req(wreq), .o_data_acknowledge_req(), .o_stop(),
    .o_sleep(sleep), .o_direction(), .o_size(size), .o_divider(), .o_multiplier(),
    .o_identifier());
  lrb_engine_model eng (.i_mclk(mclk), .i_rst(rst), .i_start_req(sreq),
    .i_wakeup_req(wreq), .i_fault(fault), .i_slow(slow), .o_bus_active(act),
    .o_evt_done(done), .o_evt_wakeup(wake), .o_evt_err(err));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Verdict in one place
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One write strobe, held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    addr = a;
    wdata = v;
    wr_s = 1'b1;
    @(posedge mclk);
    #1;
    wr_s = 1'b0;
  endtask
  // Read data is loaded on the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    #1;
    addr = a;
    rd_s = 1'b1;
    @(posedge mclk);
    #1;
    rd_s = 1'b0;
    v = rdata;
  endtask
  task automatic iwr(input logic [3:0] ia, input logic [7:0] v);
    wr(`LRB_SFR_INDADDR, {4'h0, ia});
    wr(`LRB_SFR_INDDATA, v);
  endtask
  task automatic ird(input logic [3:0] ia, input logic [7:0] e);
    wr(`LRB_SFR_INDADDR, {4'h0, ia});
    rd(`LRB_SFR_INDDATA, d);
    chk(d, e);
  endtask
  // Bounded wait for the engine to end every request
  task automatic wait_idle();
    int i;
    for (i = 0; i < 200 && (sreq !== 1'b0 || wreq !== 1'b0); i++)
      @(posedge mclk);
    #1;
    if (i == 200)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
  endtask
  initial
  begin
    {wr_s, rd_s, rx_we, fault, slow} = 5'h00;
    {addr, wdata, rx_byte} = 24'h000000;
    {rx_idx, tx_idx} = 6'h00;
    do_reset();
    rd(`LRB_SFR_CONFIG, d);
    chk(d, 8'h00);
    ird(4'h1, 8'h00);
    wr(`LRB_SFR_CONFIG, 8'h80);
    foreach (rows[k]) iwr(rows[k].a, rows[k].w);
    foreach (rows[k]) ird(rows[k].a, rows[k].e);
    chk(size, 8'h8f);
    // Config layout, unused bits read zero
    wr(`LRB_SFR_CONFIG, 8'hff);
    rd(`LRB_SFR_CONFIG, d);
    chk(d, 8'he0);
    chk({en, mst, ab}, 8'h06);
    rd(8'h90, d);
    chk(d, 8'h00);
    wr(`LRB_SFR_INDADDR, 8'hfb);
    rd(`LRB_SFR_INDADDR, d);
    chk(d, 8'h0b);
    // Failed frame blocks start and wakeup until error reset
    fault = 1'b1;
    iwr(`LRB_IND_CONTROL, 8'h01);
    wait_idle();
    fault = 1'b0;
    ird(`LRB_IND_ERROR, 8'h01);
    iwr(`LRB_IND_CONTROL, 8'h01);
    chk({7'h00, sreq}, 8'h00);
    iwr(`LRB_IND_CONTROL, 8'h02);
    chk({7'h00, wreq}, 8'h00);
    iwr(`LRB_IND_CONTROL, 8'h0c);
    ird(`LRB_IND_STATUS, 8'h00);
    ird(`LRB_IND_ERROR, 8'h00);
    // Master start now accepted and answered with done
    iwr(`LRB_IND_CONTROL, 8'h01);
    chk({7'h00, sreq}, 8'h01);
    wait_idle();
    ird(`LRB_IND_STATUS, 8'h09);
    iwr(`LRB_IND_CONTROL, 8'h08);
    // Slow wakeup sets wakeup and done
    slow = 1'b1;
    iwr(`LRB_IND_CONTROL, 8'h02);
    wait_idle();
    slow = 1'b0;
    ird(`LRB_IND_STATUS, 8'h0b);
    iwr(`LRB_IND_CONTROL, 8'h08);
    // Slave role: autobaud and sleep live, start refused
    wr(`LRB_SFR_CONFIG, 8'ha0);
    chk({7'h00, ab}, 8'h01);
    iwr(`LRB_IND_CONTROL, 8'h41);
    chk({6'h00, sreq, sleep}, 8'h01);
    // Back to master before touching data; data access is not gated by role
    wr(`LRB_SFR_CONFIG, 8'he0);
    chk({7'h00, sleep}, 8'h00);
    // Engine stores a byte, both the CPU and the engine see it
    @(posedge mclk);
    #1;
    {rx_we, rx_idx, rx_byte, tx_idx} = {1'b1, 3'h3, 8'h3c, 3'h3};
    @(posedge mclk);
    #1;
    rx_we = 1'b0;
    chk(tx_byte, 8'h3c);
    ird(4'h3, 8'h3c);
    // Reset in mid-run clears everything again
    do_reset();
    rd(`LRB_SFR_CONFIG, d);
    chk(d, 8'h00);
    ird(4'h0, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
